// ### dv/pmcc_capture_ctrl_tb_top.sv
`timescale 1ns/1ps
module pmcc_capture_ctrl_tb_top;
  import pmcc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [2:0] pprot;
  logic pready;
  logic pslverr;
  logic [31:0] prdata;
  logic overflow_irq;
  logic ext_capture;
  pmcc_txn_s txn;
  logic [31:0] rd_data;
  logic rd_err;
  logic sec = 1'b0;
  int n_mismatch = 0;
  int n_compared = 0;
  // rows: filter, control, transaction word, expected count
  localparam logic [31:0] ROWS [5][4] = '{
    '{32'hFF00_0012, 32'h0000_0000, 32'h0034_0503, 32'h3},
    '{32'h0000_0012, 32'h0001_0000, 32'h0034_0503, 32'h0},
    '{32'h0000_0012, 32'h0001_0000, 32'h0012_0503, 32'h3},
    '{32'h0005_0000, 32'h0002_0000, 32'h0012_0603, 32'h0},
    '{32'h0005_0012, 32'h0003_0000, 32'h0012_0503, 32'h3}};
  always #5 pclk = ~pclk;
  pmcc_capture_ctrl #(.SETTLE_CYCLES(10)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pprot(pprot), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .txn(txn), .ext_capture(ext_capture), .overflow_irq(overflow_irq));
  pmcc_sys_model u_sys (.pclk(pclk), .presetn(presetn), .txn(txn), .ext_capture(ext_capture));
  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pprot <= {1'b0, ~sec, 1'b0};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFF_FFFF);
    apb(1'b0, a, 32'h0);
    chk(rd_data & m, e);
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 8'h00;
    pwdata <= 32'h0;
    pprot <= 3'h2;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      rd(8'(i * 4), i == 0 ? 32'h0001_0004 : 32'h0);
    end
    apb(1'b0, 8'h1C, 32'h0);
    chk({31'h0, rd_err}, 32'h1);
    $display("test reset done");
    foreach (ROWS[i]) begin
      wr(8'h08, ROWS[i][0]);
      wr(8'h0C, ROWS[i][1]);
      wr(8'h10, 32'h0);
      u_sys.send(ROWS[i][2]);
      rd(8'h10, ROWS[i][3], 32'h7FFF_FFFF);
      rd(8'h08, ROWS[i][0] & 32'h00FF_FFFF);
    end
    $display("test match done");
    wr(8'h04, 32'h1);
    wr(8'h0C, 32'h0);
    rd(8'h10, 32'h8000_0000, 32'h8000_0000);
    wr(8'h04, 32'h0);
    rd(8'h10, 32'h3);
    repeat (12) @(posedge pclk);
    wr(8'h04, 32'h1);
    rd(8'h10, 32'hF);
    wr(8'h10, 32'h8000_0000);
    rd(8'h10, 32'h8000_0000);
    $display("test not ready done");
    wr(8'h04, 32'h0);
    wr(8'h0C, 32'h1000_0000);
    u_sys.cap();
    rd(8'h14, 32'h8000_0003);
    rd(8'h10, 32'h3);
    wr(8'h0C, 32'h1800_0000);
    u_sys.send(32'h4);
    repeat (12) @(posedge pclk);
    u_sys.cap();
    rd(8'h14, 32'h7);
    rd(8'h10, 32'h0);
    u_sys.send(32'h2);
    rd(8'h14, 32'h7);
    wr(8'h14, 32'h8000_0000);
    rd(8'h14, 32'h8000_0007);
    $display("test capture done");
    wr(8'h0C, 32'h7000_0000);
    wr(8'h10, 32'h5);
    wr(8'h18, 32'h0);
    rd(8'h14, 32'h8000_0007);
    wr(8'h18, 32'h1);
    rd(8'h14, 32'h5);
    sec = 1'b1;
    wr(8'h04, 32'h1);
    wr(8'h0C, 32'hF000_0000);
    wr(8'h10, 32'h9);
    wr(8'h04, 32'h0);
    wr(8'h10, 32'h6);
    wr(8'h18, 32'h1);
    rd(8'h14, 32'h5);
    wr(8'h04, 32'h1);
    rd(8'h14, 32'h9);
    wr(8'h18, 32'h3);
    wr(8'h04, 32'h0);
    rd(8'h14, 32'h6);
    wr(8'h04, 32'h1);
    wr(8'h10, 32'hB);
    sec = 1'b0;
    wr(8'h18, 32'h1);
    sec = 1'b1;
    rd(8'h14, 32'h9);
    $display("test trigger done");
    wr(8'h04, 32'h0);
    wr(8'h0C, 32'h0300_0000);
    wr(8'h10, 32'h7FFF_FFFF);
    u_sys.send(32'h1);
    rd(8'h0C, 32'h0700_0000);
    chk({31'h0, overflow_irq}, 32'h1);
    u_sys.send(32'h1);
    rd(8'h10, 32'h0, 32'h7FFF_FFFF);
    wr(8'h0C, 32'h0100_0000);
    rd(8'h0C, 32'h0100_0000);
    chk({31'h0, overflow_irq}, 32'h0);
    wr(8'h0C, 32'h0);
    wr(8'h10, 32'h7FFF_FFFE);
    u_sys.send(32'h3);
    rd(8'h10, 32'h1, 32'h7FFF_FFFF);
    rd(8'h0C, 32'h0400_0000);
    chk({31'h0, overflow_irq}, 32'h0);
    wr(8'h0C, 32'h00FC_FF00);
    rd(8'h0C, 32'h0);
    $display("test overflow done");
    give_verdict();
  end
  initial begin
    repeat (5000) @(posedge pclk);
    n_mismatch++;
    $display("watchdog expired");
    give_verdict();
  end
endmodule
bind pmcc_capture_ctrl pmcc_chk #(.INSTANCE_COUNT(INSTANCE_COUNT), .LOCAL_TRIGGER_PRESENT(LOCAL_TRIGGER_PRESENT)) i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pprot(pprot), .pready(pready), .pslverr(pslverr), .prdata(prdata), .txn(txn),
  .ext_capture(ext_capture), .overflow_irq(overflow_irq));

// ### dv/pmcc_chk.sv
`timescale 1ns/1ps
`include "pmcc_regs.svh"
module pmcc_chk
  import pmcc_pkg::*;
#(
  parameter int INSTANCE_COUNT = 4,
  parameter bit LOCAL_TRIGGER_PRESENT = 1'b1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [2:0] pprot,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  // traffic, capture and interrupt
  input wire pmcc_pkg::pmcc_txn_s txn,
  input wire logic ext_capture,
  input wire logic overflow_irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // capture read tracking
  // ----------------------------------------
  // any write may retarget or retrigger, so it spoils the comparison; coarse, and a capture during the read or a pprot change can still fail it falsely
  logic [31:0] cap_r;
  logic seen_r;
  logic dirty_r;
  wire cap_rd = pready && !pwrite && paddr == `PMCC_OFS_CAPTURE;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_r <= 32'h0;
      seen_r <= 1'b0;
      dirty_r <= 1'b0;
    end else begin
      if (cap_rd) begin
        cap_r <= prdata;
        seen_r <= 1'b1;
      end
      dirty_r <= cap_rd ? 1'b0 : (dirty_r || ext_capture || (psel && pwrite));
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  sequence s_rd(logic [7:0] a);
    pready && !pwrite && paddr == a;
  endsequence
  AST_ONE_WAIT: assert property (s_wait |=> pready) else $error("pready late");
  AST_PULSE: assert property (pready |=> !pready) else $error("pready stuck");
  AST_FLT_RSVD: assert property (s_rd(`PMCC_OFS_FILTER) |-> !pslverr && prdata[31:24] == 8'h00)
    else $error("filter reserved bits");
  AST_ID: assert property (s_rd(`PMCC_OFS_FEATURE_ID) |->
    prdata[15:0] == INSTANCE_COUNT[15:0] && prdata[16] == LOCAL_TRIGGER_PRESENT)
    else $error("id fields wrong");
  AST_TRIG_WO: assert property (s_rd(`PMCC_OFS_LOCAL_TRIG) |-> prdata == 32'h0)
    else $error("trigger reads nonzero");
  AST_CAP_HOLD: assert property (cap_rd && seen_r && !dirty_r |-> prdata == cap_r)
    else $error("capture changed");
  AST_IRQ_RISE: assert property ($rose(overflow_irq) |-> $past(txn.valid, 2) || $past(pready && pwrite, 2))
    else $error("irq without cause");
  AST_IRQ_FALL: assert property ($fell(overflow_irq) |-> $past(pready && pwrite, 2))
    else $error("irq fell alone");
endmodule

// ### dv/pmcc_sys_model.sv
`timescale 1ns/1ps
module pmcc_sys_model
  import pmcc_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // traffic and system capture
  output pmcc_pkg::pmcc_txn_s txn,
  output logic ext_capture
);
  initial begin
    txn = '0;
    ext_capture = 1'b0;
  end
  // idle fields are inverted so a stale transaction cannot pass for a live one
  task automatic send(input logic [31:0] w);
    @(posedge pclk);
    txn <= {1'b1, w};
    @(posedge pclk);
    txn <= {1'b0, ~w};
  endtask
  task automatic cap();
    @(posedge pclk);
    ext_capture <= 1'b1;
    @(posedge pclk);
    ext_capture <= 1'b0;
  endtask
endmodule

// ### hw/pmcc_capture_ctrl.sv
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ps
`include "pmcc_regs.svh"
module pmcc_capture_ctrl
  import pmcc_pkg::*;
#(
  parameter int INSTANCE_COUNT = 4,
  parameter bit LOCAL_TRIGGER_PRESENT = 1'b1,
  parameter bit AUTO_NOT_READY = 1'b1,
  parameter bit HAS_CLEAR_ON_CAPTURE = 1'b1,
  parameter int SETTLE_CYCLES = `PMCC_SETTLE_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [2:0] pprot,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  // monitored traffic and system capture
  input wire pmcc_pkg::pmcc_txn_s txn,
  input wire logic ext_capture,
  // interrupt
  output logic overflow_irq
);
  import pmcc_pkg::*;

  localparam int SW = $clog2(SETTLE_CYCLES + 1);
  localparam int IW = (INSTANCE_COUNT > 1) ? $clog2(INSTANCE_COUNT) : 1;
  localparam logic [SW-1:0] SETTLE_LOAD = SW'(SETTLE_CYCLES);

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  // answer comes one cycle into the access phase; writes land on the edge pready is seen
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic irq_r;
  logic [15:0] sel_r;

  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == `PMCC_OFS_FEATURE_ID) || (a == `PMCC_OFS_INST_SEL) || (a == `PMCC_OFS_FILTER) ||
                 (a == `PMCC_OFS_CONTROL) || (a == `PMCC_OFS_COUNT) || (a == `PMCC_OFS_CAPTURE) ||
                 (a == `PMCC_OFS_LOCAL_TRIG);
  endfunction

  wire access_end = psel & penable & pready_r;
  wire wr_en = access_end & pwrite & addr_known(paddr);
  wire secure_acc = ~pprot[1];
  wire sel_valid = (sel_r < 16'(INSTANCE_COUNT));
  wire [IW-1:0] sel_idx = sel_r[IW-1:0];

  wire wr_sel = wr_en & (paddr == `PMCC_OFS_INST_SEL);
  wire wr_trig = wr_en & (paddr == `PMCC_OFS_LOCAL_TRIG);

  // register hits shared by every instance's write strobes
  wire hit_flt = (paddr == `PMCC_OFS_FILTER);
  wire hit_ctl = (paddr == `PMCC_OFS_CONTROL);
  wire hit_cnt = (paddr == `PMCC_OFS_COUNT);
  wire hit_cap = (paddr == `PMCC_OFS_CAPTURE);

  // ----------------------------------------
  // local capture trigger
  // ----------------------------------------
  // no register stands behind the trigger: the write itself is the event
  wire trig_now = wr_trig & pwdata[`PMCC_TRIG_NOW_BIT] & LOCAL_TRIGGER_PRESENT;
  wire trig_ns = trig_now & ~secure_acc;
  wire trig_s = trig_now & secure_acc & ~pwdata[`PMCC_TRIG_ALL_BIT];
  wire trig_all = trig_now & secure_acc & pwdata[`PMCC_TRIG_ALL_BIT];

  // ----------------------------------------
  // per-instance state
  // ----------------------------------------
  logic [31:0] flt_q [INSTANCE_COUNT];
  logic [31:0] ctl_q [INSTANCE_COUNT];
  logic [30:0] cnt_q [INSTANCE_COUNT];
  logic not_ready_flag_q [INSTANCE_COUNT];
  logic [31:0] cap_q [INSTANCE_COUNT];
  logic [INSTANCE_COUNT-1:0] irq_vec;
  logic [INSTANCE_COUNT-1:0] access_ok;

  // writable control bits; OFLOW and SECURE are written apart, the rest read as zero
  localparam logic [31:0] CTL_MASK = (32'h1 << `PMCC_CTL_MATCH_PART) | (32'h1 << `PMCC_CTL_MATCH_GROUP) |
                                     (32'h1 << `PMCC_CTL_FREEZE) | (32'h1 << `PMCC_CTL_IRQ_EN) |
                                     (32'(HAS_CLEAR_ON_CAPTURE) << `PMCC_CTL_CLR_CAP) |
                                     (32'h7 << `PMCC_CTL_SRC_LSB);
  localparam logic [31:0] FLT_MASK = 32'h00FF_FFFF;

  genvar gi;
  generate
    for (gi = 0; gi < INSTANCE_COUNT; gi++) begin : g_mon
      logic [31:0] flt_r;
      logic [31:0] ctl_r;
      logic [30:0] cnt_r;
      logic [30:0] cnt_nxt;
      logic not_ready_flag_r;
      logic not_ready_flag_nxt;
      logic oflow_r;
      logic [SW-1:0] settle_r;
      logic [SW-1:0] settle_nxt;
      logic [31:0] cap_r;

      // only this instance is touched by a configuration access
      wire here = sel_valid & (sel_idx == IW'(gi));
      wire ok = here & (secure_acc | ~ctl_r[`PMCC_CTL_SECURE]);
      wire wr_flt = wr_en & ok & hit_flt;
      wire wr_ctl = wr_en & ok & hit_ctl;
      wire wr_cnt = wr_en & ok & hit_cnt;
      wire wr_cap = wr_en & ok & hit_cap;
      wire cfg_wr = wr_flt | wr_ctl;

      // capture subscription
      wire [2:0] src = ctl_r[`PMCC_CTL_SRC_MSB:`PMCC_CTL_SRC_LSB];
      wire is_secure = ctl_r[`PMCC_CTL_SECURE];
      wire local_hit = (is_secure ? trig_s : trig_ns) | trig_all;
      wire cap_hit = ((src == PMCC_SRC_EXTERNAL) & ext_capture) |
                     ((src == PMCC_SRC_LOCAL) & local_hit);
      wire clr_cap = ctl_r[`PMCC_CTL_CLR_CAP] & HAS_CLEAR_ON_CAPTURE;

      // filter match
      wire part_ok = ~ctl_r[`PMCC_CTL_MATCH_PART] |
                     (txn.partition_identifier == flt_r[`PMCC_FLT_PART_MSB:`PMCC_FLT_PART_LSB]);
      wire grp_ok = ~ctl_r[`PMCC_CTL_MATCH_GROUP] |
                    (txn.monitor_group == flt_r[`PMCC_FLT_GROUP_MSB:`PMCC_FLT_GROUP_LSB]);
      wire frozen = ctl_r[`PMCC_CTL_FREEZE] & oflow_r;
      wire incr = txn.valid & part_ok & grp_ok & ~frozen;
      wire [31:0] sum = {1'b0, cnt_r} + {24'h0, txn.bytes};
      wire ovf = incr & sum[31];

      // count: a capture with clear discards this cycle's increment; the new interval starts at zero
      always_comb begin
        cnt_nxt = cnt_r;
        if (wr_cnt) begin
          cnt_nxt = pwdata[30:0];
        end else if (cap_hit & clr_cap) begin
          cnt_nxt = 31'h0;
        end else if (incr) begin
          cnt_nxt = sum[30:0];
        end
      end

      // not-ready: config write restarts settling; capture or settle expiry clears it
      always_comb begin
        not_ready_flag_nxt = not_ready_flag_r;
        if (AUTO_NOT_READY && cfg_wr) begin
          not_ready_flag_nxt = 1'b1;
        end else if (wr_cnt) begin
          not_ready_flag_nxt = pwdata[`PMCC_NOT_READY_FLAG_BIT];
        end else if (AUTO_NOT_READY && cap_hit) begin
          not_ready_flag_nxt = 1'b0;
        end else if (AUTO_NOT_READY && settle_r == SW'(1)) begin
          not_ready_flag_nxt = 1'b0;
        end
      end

      // settle counter reloads on every settings write, then runs down to zero
      always_comb begin
        settle_nxt = settle_r;
        if (AUTO_NOT_READY && cfg_wr) begin
          settle_nxt = SETTLE_LOAD;
        end else if (settle_r != '0) begin
          settle_nxt = settle_r - SW'(1);
        end
      end

      logic [31:0] flt_nxt;
      logic [31:0] ctl_nxt;
      logic oflow_nxt;
      logic [31:0] cap_nxt;

      // ----------------------------------------
      // configuration and status next values
      // ----------------------------------------
      // masks keep unused fields reading as zero
      always_comb begin
        flt_nxt = flt_r;
        if (wr_flt) begin
          flt_nxt = pwdata & FLT_MASK;
        end
      end

      // the secure bit is only taken from a secure write
      always_comb begin
        ctl_nxt = ctl_r;
        if (wr_ctl) begin
          ctl_nxt = (pwdata & CTL_MASK) | ({31'h0, secure_acc & pwdata[`PMCC_CTL_SECURE]} << 31);
        end
      end

      // hardware set beats a software clear in the same cycle
      always_comb begin
        oflow_nxt = oflow_r;
        if (ovf) begin
          oflow_nxt = 1'b1;
        end else if (wr_ctl) begin
          oflow_nxt = pwdata[`PMCC_CTL_OFLOW];
        end
      end

      // capture takes the value from before this edge, so a clear never loses it
      always_comb begin
        cap_nxt = cap_r;
        if (cap_hit) begin
          cap_nxt = {not_ready_flag_r, cnt_r};
        end else if (wr_cap) begin
          cap_nxt[`PMCC_NOT_READY_FLAG_BIT] = pwdata[`PMCC_NOT_READY_FLAG_BIT];
        end
      end

      // ----------------------------------------
      // instance registers
      // ----------------------------------------
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          flt_r <= `PMCC_RST_WORD;
          ctl_r <= `PMCC_RST_WORD;
        end else begin
          flt_r <= flt_nxt;
          ctl_r <= ctl_nxt;
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt_r <= 31'h0;
        end else begin
          cnt_r <= cnt_nxt;
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          not_ready_flag_r <= 1'b0;
          settle_r <= '0;
        end else begin
          not_ready_flag_r <= not_ready_flag_nxt;
          settle_r <= settle_nxt;
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          oflow_r <= 1'b0;
          cap_r <= `PMCC_RST_WORD;
        end else begin
          oflow_r <= oflow_nxt;
          cap_r <= cap_nxt;
        end
      end

      assign flt_q[gi] = flt_r;
      assign ctl_q[gi] = ctl_r | ({31'h0, oflow_r} << `PMCC_CTL_OFLOW);
      assign cnt_q[gi] = cnt_r;
      assign not_ready_flag_q[gi] = not_ready_flag_r;
      assign cap_q[gi] = cap_r;
      assign irq_vec[gi] = oflow_r & ctl_r[`PMCC_CTL_IRQ_EN];
      assign access_ok[gi] = ok;
    end
  endgenerate

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  // a non-secure read of a secure instance sees zero, like an absent instance
  wire inst_ok = sel_valid & access_ok[sel_idx];
  wire [31:0] id_word = 32'(INSTANCE_COUNT) | (32'(LOCAL_TRIGGER_PRESENT) << `PMCC_ID_LOCAL_BIT);
  logic [31:0] rdata;

  always_comb begin
    rdata = 32'h0;
    unique case (paddr)
      `PMCC_OFS_FEATURE_ID: rdata = id_word;
      `PMCC_OFS_INST_SEL: rdata = {16'h0, sel_r};
      `PMCC_OFS_FILTER: rdata = inst_ok ? flt_q[sel_idx] : 32'h0;
      `PMCC_OFS_CONTROL: rdata = inst_ok ? ctl_q[sel_idx] : 32'h0;
      `PMCC_OFS_COUNT: rdata = inst_ok ? {not_ready_flag_q[sel_idx], cnt_q[sel_idx]} : 32'h0;
      `PMCC_OFS_CAPTURE: rdata = inst_ok ? cap_q[sel_idx] : 32'h0;
      default: rdata = 32'h0;
    endcase
  end

  // ----------------------------------------
  // bus answer
  // ----------------------------------------
  // one wait state on every access, so the answer comes straight from flip-flops
  logic pready_nxt;
  logic pslverr_nxt;
  logic [31:0] prdata_nxt;
  logic [15:0] sel_nxt;
  wire access_start = psel & penable & ~pready_r;

  always_comb begin
    pready_nxt = access_start;
    pslverr_nxt = 1'b0;
    prdata_nxt = prdata_r;
    if (access_start) begin
      pslverr_nxt = ~addr_known(paddr);
      prdata_nxt = pwrite ? 32'h0 : rdata;
    end
  end

  always_comb begin
    sel_nxt = sel_r;
    if (wr_sel) begin
      sel_nxt = pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0;
    end else begin
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_r <= 16'h0;
    end else begin
      sel_r <= sel_nxt;
    end
  end

  // ----------------------------------------
  // interrupt
  // ----------------------------------------
  // a level, so an interrupt controller that misses an edge still sees it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |irq_vec;
    end
  end

  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign prdata = prdata_r;
  assign overflow_irq = irq_r;

endmodule

// ### hw/pmcc_pkg.sv
package pmcc_pkg;

  // ----------------------------------------
  // capture source codes
  // ----------------------------------------
  typedef enum logic [2:0] {
    PMCC_SRC_NONE = 3'b000,
    PMCC_SRC_EXTERNAL = 3'b001,
    PMCC_SRC_LOCAL = 3'b111
  } pmcc_src_e;

  // ----------------------------------------
  // monitored transaction
  // ----------------------------------------
  typedef struct packed {
    logic valid;
    logic [15:0] partition_identifier;
    logic [7:0] monitor_group;
    logic [7:0] bytes;
  } pmcc_txn_s;

  // ----------------------------------------
  // apb answer
  // ----------------------------------------
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } pmcc_apb_rsp_s;

endpackage

// ### hw/pmcc_regs.svh
`ifndef PMCC_REGS_SVH
`define PMCC_REGS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define PMCC_OFS_FEATURE_ID 8'h00
`define PMCC_OFS_INST_SEL 8'h04
`define PMCC_OFS_FILTER 8'h08
`define PMCC_OFS_CONTROL 8'h0C
`define PMCC_OFS_COUNT 8'h10
`define PMCC_OFS_CAPTURE 8'h14
`define PMCC_OFS_LOCAL_TRIG 8'h18

// ----------------------------------------
// field positions
// ----------------------------------------
`define PMCC_FLT_PART_LSB 0
`define PMCC_FLT_PART_MSB 15
`define PMCC_FLT_GROUP_LSB 16
`define PMCC_FLT_GROUP_MSB 23
`define PMCC_CTL_MATCH_PART 16
`define PMCC_CTL_MATCH_GROUP 17
`define PMCC_CTL_FREEZE 24
`define PMCC_CTL_IRQ_EN 25
`define PMCC_CTL_OFLOW 26
`define PMCC_CTL_CLR_CAP 27
`define PMCC_CTL_SRC_LSB 28
`define PMCC_CTL_SRC_MSB 30
`define PMCC_CTL_SECURE 31
`define PMCC_NOT_READY_FLAG_BIT 31
`define PMCC_TRIG_NOW_BIT 0
`define PMCC_TRIG_ALL_BIT 1
`define PMCC_ID_LOCAL_BIT 16

// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define PMCC_RST_WORD 32'h0000_0000
`define PMCC_CLK_MHZ 100
`define PMCC_MAX_SETTLE_US 20
`define PMCC_SETTLE_CYCLES (`PMCC_MAX_SETTLE_US * `PMCC_CLK_MHZ)

`endif
